// File: common/bcx_pkg.sv
/*
 * Shared constants and carrier types for the branch, call and stack
 * extension decoder.
 * Assumes a core clock split into four phases per instruction cycle.
 */
package bcx_pkg;

	// Widths of the program counter, data pointers and relative offsets
	localparam int PC_W = 21;
	localparam int PTR_W = 12;
	localparam int OFS_W = 11;

	// Phase numbers within one instruction cycle
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q4 = 2'h3;
	localparam logic [1:0] PH_RESET = 2'h0;

	// Opcode patterns
	localparam logic [7:0] OP_CARRY_CLEAR = 8'he3;
	localparam logic [7:0] OP_NEG_CLEAR = 8'he7;
	localparam logic [4:0] OP_REL_CALL = 5'h1b;
	localparam logic [15:0] OP_SOFT_RESET = 16'h00ff;
	localparam logic [15:0] OP_CALL_WORK = 16'h0014;
	localparam logic [7:0] OP_PTR_ADD = 8'he8;
	localparam logic [7:0] OP_PTR_SUB = 8'he9;
	localparam logic [7:0] OP_PUSH_LIT = 8'hea;
	localparam logic [7:0] OP_MOVE = 8'heb;
	localparam logic [3:0] OP_MOVE_WORD2 = 4'hf;
	localparam logic [1:0] PTR_THIRD = 2'h3;
	localparam logic [1:0] PTR_SEL_THIRD = 2'h2;

	// Highest file address that becomes an offset in indexed mode
	localparam logic [7:0] IDX_LIMIT = 8'h5f;

	// Program counter change request
	typedef struct packed {
		logic write;
		logic [PC_W-1:0] target;
	} bcx_pc_cmd_type;

	// Return stack request
	typedef struct packed {
		logic push;
		logic pop;
		logic [PC_W-1:0] data;
	} bcx_stack_cmd_type;

	// File select pointer update
	typedef struct packed {
		logic write;
		logic [1:0] sel;
		logic [PTR_W-1:0] value;
	} bcx_ptr_cmd_type;

	// Data memory access
	typedef struct packed {
		logic write;
		logic [PTR_W-1:0] addr;
		logic [7:0] data;
	} bcx_mem_cmd_type;

	// The three file select pointers as the core holds them
	typedef struct packed {
		logic [PTR_W-1:0] p2;
		logic [PTR_W-1:0] p1;
		logic [PTR_W-1:0] p0;
	} bcx_ptrs_type;

endpackage

// File: design/bcx_target_calc.sv
/*
 * Relative target adder: incremented PC plus twice a signed offset.
 * Assumes the PC input already points past the current instruction.
 */
`timescale 1ns/1ns
`default_nettype none
module bcx_target_calc #(
	parameter int PCW = 21,
	parameter int OW = 11
) (
	// Operands
	input wire logic [PCW-1:0] pcNow,
	input wire logic [OW-1:0] offset,
	// Result
	output logic [PCW-1:0] target
);
	// Sign extend, double, add; the sum wraps in the program space
	wire logic [PCW-1:0] scaled;
	assign scaled = {{(PCW-OW-1){offset[OW-1]}}, offset, 1'b0};
	assign target = pcNow + scaled;
endmodule
`default_nettype wire

// File: design/bcx_decoder.sv
/*
 * Decode and execute for relative branches, relative call, software
 * reset and the optional stack-oriented extension with indexed offsets.
 * Assumes fetch holds a word for a whole four-phase cycle, pcNow already
 * incremented, and the core applies the commands issued in Q4.
 */
`timescale 1ns/1ns
`default_nettype none
module bcx_decoder
	import bcx_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fetch side
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire logic [PC_W-1:0] pcNow,
	// Core state
	input wire logic carryFlag,
	input wire logic negFlag,
	input wire logic [7:0] workReg,
	input wire logic [PC_W-9:0] pcLatch,
	input wire logic [PC_W-1:0] stackTop,
	input wire bcx_ptrs_type ptrs,
	input wire logic [7:0] memRdData,
	// Configuration pin
	input wire logic extSetConfig,
	// Commands to the core
	output bcx_pc_cmd_type pcCmd,
	output bcx_stack_cmd_type stackCmd,
	output bcx_ptr_cmd_type ptrCmd,
	output bcx_mem_cmd_type memCmd,
	output logic memRead,
	output logic [PTR_W-1:0] memRdAddr,
	output logic softReset,
	output logic idxActive,
	output logic [PTR_W-1:0] idxAddr,
	output logic fetchFlush
);
	typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_MOVE2} bcx_state_type;

	// Pointer select shared by the adjust and literal-push paths
	function automatic logic [PTR_W-1:0] ptrOf(bcx_ptrs_type p,
		logic [1:0] s);
		case (s)
			2'h0: ptrOf = p.p0;
			2'h1: ptrOf = p.p1;
			default: ptrOf = p.p2;
		endcase
	endfunction

	bcx_state_type state, next_state;
	logic [1:0] phase;
	logic extMeta, extOn;
	logic [7:0] srcData;
	logic [15:0] firstWord;

	// Configuration bit crosses in through two flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			extMeta <= 1'b0;
			extOn <= 1'b0;
		end else begin
			extMeta <= extSetConfig;
			extOn <= extMeta;
		end
	end

	// Decode of the held word
	wire logic live, atQ4, isCarryBr, isNegBr, isRelCall, isSoftRst;
	wire logic isCallW, isAdd, isSub, isPush, isMove, isUnlink, taken;
	wire logic isFileOp;
	assign live = instrValid && state == ST_RUN;
	assign atQ4 = phase == PH_Q4;
	assign isCarryBr = instrWord[15:8] == OP_CARRY_CLEAR;
	assign isNegBr = instrWord[15:8] == OP_NEG_CLEAR;
	assign isRelCall = instrWord[15:11] == OP_REL_CALL;
	assign isSoftRst = instrWord == OP_SOFT_RESET;
	// extended opcodes only exist while the bit is set
	assign isCallW = extOn && instrWord == OP_CALL_WORK;
	assign isAdd = extOn && instrWord[15:8] == OP_PTR_ADD;
	assign isSub = extOn && instrWord[15:8] == OP_PTR_SUB;
	assign isPush = extOn && instrWord[15:8] == OP_PUSH_LIT;
	assign isMove = extOn && instrWord[15:8] == OP_MOVE;
	// pointer field three means adjust and return
	assign isUnlink = (isAdd || isSub) && instrWord[7:6] == PTR_THIRD;
	assign taken = (isCarryBr && !carryFlag) || (isNegBr && !negFlag);
	// Byte and bit oriented opcodes that carry a file field
	assign isFileOp = (instrWord[15:12] != 4'h0 && instrWord[15:12] <= 4'hb)
		|| instrWord[15:9] == 7'h01;

	// short offsets sign-extended to the call width
	wire logic [OFS_W-1:0] offset;
	wire logic [PC_W-1:0] relTarget;
	assign offset = isRelCall ? instrWord[10:0]
		: {{(OFS_W-8){instrWord[7]}}, instrWord[7:0]};
	bcx_target_calc #(.PCW(PC_W), .OW(OFS_W)) u_bcx_target_calc (
		.pcNow(pcNow),
		.offset(offset),
		.target(relTarget)
	);

	// Q4 command values; everything idle outside Q4
	wire logic [1:0] ptrSel;
	wire logic [PTR_W-1:0] ptrVal, lit6, ptr2;
	wire logic jump, moveDone;
	// Nets, since each field has its own continuous assignment
	wire bcx_pc_cmd_type next_pcCmd;
	wire bcx_stack_cmd_type next_stackCmd;
	wire bcx_ptr_cmd_type next_ptrCmd;
	wire bcx_mem_cmd_type next_memCmd;
	assign ptr2 = ptrs.p2;
	assign ptrSel = isPush ? PTR_SEL_THIRD : instrWord[7:6];
	assign ptrVal = ptrOf(ptrs, ptrSel);
	assign lit6 = {{(PTR_W-6){1'b0}}, instrWord[5:0]};
	// jumps that leave an idle cycle
	assign jump = live && (taken || isRelCall || isCallW || isUnlink);
	assign moveDone = state == ST_MOVE2 && instrValid
		&& instrWord[15:12] == OP_MOVE_WORD2;
	assign next_pcCmd.write = atQ4 && jump;
	assign next_pcCmd.target = isUnlink ? stackTop
		: isCallW ? {pcLatch, workReg} : relTarget;
	// next address goes on the stack with the PC write
	assign next_stackCmd.push = atQ4 && live && (isRelCall || isCallW);
	assign next_stackCmd.pop = atQ4 && live && isUnlink;
	assign next_stackCmd.data = pcNow;
	assign next_ptrCmd.write = atQ4 && live && (isAdd || isSub || isPush);
	assign next_ptrCmd.sel = isUnlink ? PTR_SEL_THIRD : ptrSel;
	assign next_ptrCmd.value = isPush ? ptrVal - 12'h001
		: isSub ? ptrVal - lit6 : ptrVal + lit6;
	// second word writes absolute or indexed destination
	assign next_memCmd.write = atQ4 && ((live && isPush) || moveDone);
	assign next_memCmd.addr = moveDone ? (firstWord[7] ?
		ptr2 + {{(PTR_W-7){1'b0}}, instrWord[6:0]} : instrWord[11:0])
		: ptr2;
	assign next_memCmd.data = moveDone ? srcData : instrWord[7:0];

	// State after each instruction cycle
	always_comb begin
		next_state = state;
		if (atQ4) begin
			case (state)
				ST_RUN: begin
					if (jump)
						next_state = ST_IDLE;
					else if (live && isMove)
						next_state = ST_MOVE2;
				end
				default: next_state = ST_RUN;
			endcase
		end
	end

	// Phase counter and sequencing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= PH_RESET;
			state <= ST_RUN;
		end else begin
			phase <= phase + 2'h1;
			state <= next_state;
		end
	end

	// Command pulses, all registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pcCmd <= '0;
			stackCmd <= '0;
			ptrCmd <= '0;
			memCmd <= '0;
		end else begin
			pcCmd <= next_pcCmd;
			stackCmd <= next_stackCmd;
			ptrCmd <= next_ptrCmd;
			memCmd <= next_memCmd;
		end
	end

	// reset pulse appears in Q2; the core clears as on master clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			softReset <= 1'b0;
		else
			softReset <= phase == PH_Q1 && live && isSoftRst;
	end

	// source read of the move, captured in Q4 for the second word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			memRead <= 1'b0;
			memRdAddr <= '0;
			srcData <= '0;
			firstWord <= '0;
		end else begin
			memRead <= phase == PH_Q1 && live && isMove;
			memRdAddr <= ptr2 + {{(PTR_W-7){1'b0}}, instrWord[6:0]};
			if (atQ4 && live && isMove) begin
				srcData <= memRdData;
				firstWord <= instrWord;
			end
		end
	end

	// low access-bank files become third-pointer offsets
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idxActive <= 1'b0;
			idxAddr <= '0;
		end else if (phase == PH_Q1) begin
			idxActive <= live && extOn && isFileOp && !instrWord[8]
				&& instrWord[7:0] <= IDX_LIMIT;
			idxAddr <= ptr2 + {{(PTR_W-8){1'b0}}, instrWord[7:0]};
		end
	end

	// Fetch discards the word of an idle cycle
	assign fetchFlush = state == ST_IDLE;

	chk_carry_taken: assert property (@(posedge clk) disable iff (rst)
		atQ4 && live && isCarryBr && !carryFlag |=>
		pcCmd.write && pcCmd.target == $past(relTarget))
		else $error("carry-clear branch not taken");
	chk_carry_held: assert property (@(posedge clk) disable iff (rst)
		atQ4 && live && isCarryBr && carryFlag |=> !pcCmd.write ##1
		state == ST_RUN)
		else $error("carry-clear branch wrongly taken");
	chk_neg_branch: assert property (@(posedge clk) disable iff (rst)
		atQ4 && live && isNegBr |=> pcCmd.write == !$past(negFlag))
		else $error("negative-clear branch wrong");
	chk_idle_cycle: assert property (@(posedge clk) disable iff (rst)
		pcCmd.write |-> fetchFlush [*4] ##1 !fetchFlush)
		else $error("jump idle cycle not four phases");
	chk_call_push: assert property (@(posedge clk) disable iff (rst)
		stackCmd.push |-> pcCmd.write && stackCmd.data == $past(pcNow))
		else $error("call push not with pc write");
	chk_reset_q2: assert property (@(posedge clk) disable iff (rst)
		softReset |-> phase == PH_Q2 && $past(instrWord) == OP_SOFT_RESET)
		else $error("soft reset outside Q2");
	chk_ext_gate: assert property (@(posedge clk) disable iff (rst)
		ptrCmd.write || memRead |-> $past(extOn))
		else $error("extension acted while disabled");
	chk_push_dec: assert property (@(posedge clk) disable iff (rst)
		memCmd.write && ptrCmd.write |->
		ptrCmd.value == memCmd.addr - 12'h001 && ptrCmd.sel == 2'h2)
		else $error("literal push pointer not decremented");
	chk_unlink_ret: assert property (@(posedge clk) disable iff (rst)
		stackCmd.pop |-> pcCmd.write && ptrCmd.write && ptrCmd.sel == 2'h2)
		else $error("adjust and return incomplete");
endmodule
`default_nettype wire

// File: dv/bcx_decoder_tb.sv
/*
 * Self-checking bench for the branch, call and stack extension decoder.
 * Assumes the core's four-phase cycle starts at the first edge after
 * reset and that commands land one clock after the Q4 edge.
 */
`timescale 1ns/1ns
`default_nettype none
module bcx_decoder_tb
	import bcx_pkg::*;
;
	// Stimulus and observed signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic instrValid = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic [PC_W-1:0] pcNow = 21'h1ffff0;
	logic carryFlag = 1'b0;
	logic negFlag = 1'b0;
	logic [7:0] workReg = 8'h9d;
	logic [PC_W-9:0] pcLatch = 13'h0a5a;
	logic [PC_W-1:0] stackTop = 21'h012344;
	bcx_ptrs_type ptrs = {12'hfc0, 12'h7c0, 12'h010};
	logic [7:0] memRdData = 8'h3c;
	logic extSetConfig = 1'b0;
	bcx_pc_cmd_type pcCmd;
	bcx_stack_cmd_type stackCmd;
	bcx_ptr_cmd_type ptrCmd;
	bcx_mem_cmd_type memCmd;
	logic memRead;
	logic [PTR_W-1:0] memRdAddr;
	logic softReset;
	logic idxActive;
	logic [PTR_W-1:0] idxAddr;
	logic fetchFlush;
	logic [3:0] sr;
	logic [3:0] mr;
	int failCount = 0;
	int samplesChecked = 0;

	bcx_decoder u_bcx_decoder (
		.clk(clk), .rst(rst), .instrValid(instrValid),
		.instrWord(instrWord), .pcNow(pcNow), .carryFlag(carryFlag),
		.negFlag(negFlag), .workReg(workReg), .pcLatch(pcLatch),
		.stackTop(stackTop), .ptrs(ptrs), .memRdData(memRdData),
		.extSetConfig(extSetConfig), .pcCmd(pcCmd), .stackCmd(stackCmd),
		.ptrCmd(ptrCmd), .memCmd(memCmd), .memRead(memRead),
		.memRdAddr(memRdAddr), .softReset(softReset),
		.idxActive(idxActive), .idxAddr(idxAddr), .fetchFlush(fetchFlush)
	);

	// Free-running 100 MHz core clock
	always #5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failCount++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One instruction cycle; Q2 pulses are captured on the way
	task automatic cyc(input logic [15:0] w);
		instrWord <= w;
		instrValid <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			sr[i] = softReset;
			mr[i] = memRead;
		end
	endtask

	// Payloads are only meaningful while their strobe is high
	task automatic cmds(input logic [21:0] p, input logic [22:0] s,
		input logic [14:0] f, input logic [20:0] m);
		check(32'({pcCmd.write, pcCmd.write ? pcCmd.target : 21'h0}), 32'(p));
		check(32'({stackCmd.push, stackCmd.pop,
			stackCmd.push ? stackCmd.data : 21'h0}), 32'(s));
		check(32'({ptrCmd.write, ptrCmd.write ? ptrCmd[13:0] : 14'h0}), 32'(f));
		check(32'({memCmd.write, memCmd.write ? memCmd[19:0] : 20'h0}), 32'(m));
	endtask

	function automatic logic [PC_W-1:0] rel(input int n);
		return pcNow + PC_W'(2 * n);
	endfunction

	// A jump is followed by an idle cycle that ignores even another jump
	task automatic flushIdle();
		check(32'(fetchFlush), 32'h1);
		cyc({OP_REL_CALL, 11'h001});
		cmds('0, '0, '0, '0);
		check(32'(fetchFlush), 32'h0);
	endtask

	task automatic t_branch();
		logic taken;
		int n;
		for (int i = 0; i < 8; i++) begin
			carryFlag <= i[0];
			negFlag <= i[1];
			taken = i[2] ? !i[1] : !i[0];
			n = i[1] ? -128 : 127;
			cyc({i[2] ? OP_NEG_CLEAR : OP_CARRY_CLEAR, 8'(n)});
			cmds(taken ? {1'b1, rel(n)} : 22'h0, '0, '0, '0);
			if (taken) begin
				flushIdle();
			end else begin
				check(32'(fetchFlush), 32'h0);
			end
		end
		$display("done: branches");
	endtask

	task automatic t_ext_off();
		cyc({OP_PTR_ADD, 8'h7f});
		cmds('0, '0, '0, '0);
		cyc({OP_PUSH_LIT, 8'h5a});
		cmds('0, '0, '0, '0);
		cyc(OP_CALL_WORK);
		cmds('0, '0, '0, '0);
		check(32'(fetchFlush), 32'h0);
		cyc(16'h6a10);
		check(32'(idxActive), 32'h0);
		extSetConfig <= 1'b1;
		cyc(16'h0000);
		$display("done: extension off");
	endtask

	task automatic t_calls();
		cyc(OP_SOFT_RESET);
		check(32'(sr), 32'h1);
		cmds('0, '0, '0, '0);
		for (int i = 0; i < 2; i++) begin
			cyc({OP_REL_CALL, i ? 11'h3ff : 11'h400});
			cmds({1'b1, rel(i ? 1023 : -1024)}, {2'b10, pcNow}, '0, '0);
			flushIdle();
		end
		cyc(OP_CALL_WORK);
		cmds({1'b1, pcLatch, workReg}, {2'b10, pcNow}, '0, '0);
		flushIdle();
		$display("done: calls and reset");
	endtask

	task automatic t_ptr();
		logic [11:0] base;
		logic [11:0] val;
		for (int s = 0; s < 4; s++) begin
			for (int o = 0; o < 2; o++) begin
				base = (s == 0) ? ptrs.p0 : (s == 1) ? ptrs.p1 : ptrs.p2;
				val = o ? base - 12'h03f : base + 12'h03f;
				cyc({o ? OP_PTR_SUB : OP_PTR_ADD, 2'(s), 6'h3f});
				if (s == 3) begin
					cmds({1'b1, stackTop}, {2'b01, 21'h0}, {3'b110, val}, '0);
					flushIdle();
				end else begin
					cmds('0, '0, {1'b1, 2'(s), val}, '0);
				end
			end
		end
		cyc({OP_PUSH_LIT, 8'ha5});
		cmds('0, '0, {3'b110, ptrs.p2 - 12'h001}, {1'b1, ptrs.p2, 8'ha5});
		$display("done: pointer ops");
	endtask

	// Absolute, indexed and malformed second word; the read byte changes
	// before the absolute and indexed second words, so a late capture of the source shows up
	task automatic t_move();
		cyc({OP_MOVE, 8'h7f});
		check(32'(mr), 32'h1);
		// Concatenation keeps the sum at 12 bits so it wraps like the pointer
		check(32'(memRdAddr), {20'h0, ptrs.p2 + 12'h07f});
		memRdData <= 8'hc3;
		cyc(16'hf123);
		cmds('0, '0, '0, {1'b1, 12'h123, 8'h3c});
		cyc({OP_MOVE, 8'h85});
		memRdData <= 8'h69;
		cyc(16'hf0c7);
		cmds('0, '0, '0, {1'b1, ptrs.p2 + 12'h047, 8'hc3});
		cyc({OP_MOVE, 8'h01});
		cyc(16'h0123);
		cmds('0, '0, '0, '0);
		$display("done: moves");
	endtask

	task automatic t_index();
		cyc(16'h6a5f);
		check(32'(idxActive), 32'h1);
		check(32'(idxAddr), {20'h0, ptrs.p2 + 12'h05f});
		cyc(16'h6a60);
		check(32'(idxActive), 32'h0);
		cyc(16'h6b10);
		check(32'(idxActive), 32'h0);
		$display("done: indexed addressing");
	endtask

	// Main sequence; reset is released on an edge so Q1 follows it
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_branch();
		t_ext_off();
		t_calls();
		t_ptr();
		t_move();
		t_index();
		conclude();
	end

	// Guard against a hang; the full run needs far fewer cycles
	initial begin
		#500000;
		failCount++;
		conclude();
	end
endmodule
`default_nettype wire
